// file: design/uart_register_interface.sv
// Serial port register side: data port, status, enables, shared location.
// Notes on behaviour
// - Back-to-back shared read returns frame control.
// - Single isolated shared read gives divisor high.
// - Data writes fill tx buffer; reads give rx.
// - Short characters: upper tx ignored, rx zeroed.
// - Data write while buffer full is dropped.
// - Enabled transmitter loads shifter then sends serially.
// - Two-entry rx FIFO advances on data read.
// - Rx complete tracks FIFO nonempty; disable flushes.
// - Tx complete sets at frame end with buffer empty; clearable.
// - Tx buffer empty reads one; one after reset.
// - Frame error follows head FIFO character.
// - Overrun when FIFO full, shifter full, start.
// - Parity error follows head character, if checking.
// - Double speed halves oversampling in async mode.
// - Multiprocessor filter drops non-address frames.
// - Interrupt needs enable, global flag and status.
// - Receiver takes pin; disable flushes, clears errors.
// - Transmitter disable waits until everything drained.
// - Shared write top bit picks target register.
`timescale 1ns/1ns
module uart_register_interface (
  input wire logic clk,
  input wire logic rst_n,
  input wire uart_regs_pkg::io_req_t io_req,
  output logic [7:0] io_rdata,
  input wire logic global_irq_on,
  input wire logic txc_irq_ack,
  input wire logic rxd_in,
  output logic txd_out,
  output logic txd_oe,
  output logic rxd_owned,
  output logic rxc_irq,
  output logic txc_irq,
  output logic tx_buffer_empty_flag_irq
);
  import uart_regs_pkg::*;

  // ==========================================================
  // Reset release
  logic rst_meta_ff, rst_sync_ff;
  // Two-stage release of the asynchronous reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  wire logic srst_n = rst_sync_ff;
  // Checks sample on the rising edge and rest while reset is held
  default clocking chk_cb @(posedge clk); endclocking
  default disable iff (!srst_n);

  // ==========================================================
  // Register state
  logic [7:0] stat_ff;       // Writable bits of status: speed, filter
  logic [7:0] enab_ff;       // Enable/control register
  logic [7:0] frame_ff;      // Frame control register
  logic [3:0] baud_hi_ff;    // Divisor high nibble
  logic [7:0] baud_lo_ff;    // Divisor low byte
  logic shared_rd_ff;        // Shared location read last cycle
  logic txc_ff;              // Transmit complete flag
  logic ovr_ff;              // Overrun flag
  logic [8:0] tx_buf_ff;     // Transmit holding buffer
  logic tx_full_ff;          // Holding buffer occupied
  rx_char_t fifo_ff [FIFO_DEPTH];  // Receive FIFO
  logic [1:0] fifo_cnt_ff;   // Entries held
  logic rd_ptr_ff;           // Head index

  // Access decode
  wire logic rd_data = io_req.rd && io_req.addr == ADDR_DATA;
  wire logic wr_data = io_req.wr && io_req.addr == ADDR_DATA;
  wire logic wr_stat = io_req.wr && io_req.addr == ADDR_STAT;
  wire logic wr_enab = io_req.wr && io_req.addr == ADDR_ENAB;
  wire logic wr_shared = io_req.wr && io_req.addr == ADDR_SHARED;
  wire logic rd_shared = io_req.rd && io_req.addr == ADDR_SHARED;
  wire logic wr_baud_lo = io_req.wr && io_req.addr == ADDR_BAUD_LOW;
  wire logic rx_on = enab_ff[RXON_BIT];
  wire logic tx_on = enab_ff[TXON_BIT];

  // Character width mask from size code (5..9 bits)
  function automatic logic [8:0] size_mask(input logic [2:0] code);
    case (code)
      3'h0: size_mask = 9'h01F;
      3'h1: size_mask = 9'h03F;
      3'h2: size_mask = 9'h07F;
      3'h7: size_mask = 9'h1FF;
      default: size_mask = 9'h0FF;
    endcase
  endfunction
  wire logic [2:0] size_code = {enab_ff[SIZE2_BIT], frame_ff[2:1]};
  wire logic [8:0] cmask = size_mask(size_code);
  wire logic nine_bit = size_code == 3'h7;

  // ==========================================================
  // Baud timing
  wire logic [11:0] divisor = {baud_hi_ff, baud_lo_ff};
  // Async double speed halves oversampling; sync ignores it
  wire logic [4:0] ovs = (stat_ff[DSPD_BIT] && !frame_ff[SYNC_BIT])
                         ? OVS_DOUBLE : OVS_NORMAL;
  logic [11:0] pre_ff;
  logic [4:0] ovs_cnt_ff;
  wire logic tick = pre_ff == 12'h000;
  wire logic bit_tick = tick && ovs_cnt_ff >= ovs - 5'h01;
  // Prescaler and oversample counter; low byte write restarts it
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      pre_ff <= 12'h000;
      ovs_cnt_ff <= 5'h00;
    end else begin
      pre_ff <= (tick || wr_baud_lo) ? divisor : pre_ff - 12'h001;
      if (wr_baud_lo || bit_tick) ovs_cnt_ff <= 5'h00;
      else if (tick) ovs_cnt_ff <= ovs_cnt_ff + 5'h01;
    end
  end

  // ==========================================================
  // Transmitter
  logic [11:0] tx_sh_ff;     // Frame bits, LSB first
  logic [3:0] tx_left_ff;    // Bits still to send
  logic tx_line_ff;
  logic tx_drive_ff;         // Pin owned by transmitter
  wire logic tx_idle = tx_left_ff == 4'h0;
  wire logic [8:0] tx_chr = tx_buf_ff & cmask;
  wire logic tx_par = ^tx_chr ^ frame_ff[PAR0_BIT];
  wire logic tx_load = (tx_on || tx_drive_ff)
                       && tx_full_ff && tx_idle;
  wire logic tx_done = bit_tick && tx_left_ff == 4'h1;
  // Frame length: start, data, optional parity, stop bits
  wire logic [3:0] tx_len = 4'h1 + 4'h5
    + (nine_bit ? 4'h4 : {2'h0, size_code[1:0]})
    + {3'h0, frame_ff[PAR1_BIT]} + {3'h0, frame_ff[STOP2_BIT]} + 4'h1;
  // Pack data, parity and stop bits behind the start bit
  logic [11:0] tx_frame;
  always_comb begin
    tx_frame = 12'hFFF;
    for (int i = 0; i < 9; i++) begin
      if (cmask[i]) tx_frame[i + 1] = tx_chr[i];
    end
    if (frame_ff[PAR1_BIT]) begin
      tx_frame[4'h6 + {2'h0, size_code == 3'h7 ? 2'h3 : size_code[1:0]}
               + {3'h0, nine_bit}] = tx_par;
    end
    tx_frame[0] = 1'b0;
  end
  // Shift out one bit per bit period
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      tx_sh_ff <= 12'hFFF;
      tx_left_ff <= 4'h0;
      tx_line_ff <= 1'b1;
    end else if (tx_load) begin
      tx_sh_ff <= tx_frame;
      tx_left_ff <= tx_len;
    end else if (bit_tick && !tx_idle) begin
      tx_line_ff <= tx_sh_ff[0];
      tx_sh_ff <= {1'b1, tx_sh_ff[11:1]};
      tx_left_ff <= tx_left_ff - 4'h1;
    end
  end
  // Holding buffer; writes while occupied are dropped
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      tx_buf_ff <= 9'h000;
      tx_full_ff <= 1'b0;
    end else if (wr_data && !tx_full_ff) begin
      tx_buf_ff <= {enab_ff[TX9_BIT], io_req.wdata};
      tx_full_ff <= 1'b1;
    end else if (tx_load) begin
      tx_full_ff <= 1'b0;
    end
  end
  // Pin ownership; release deferred until drained
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) tx_drive_ff <= 1'b0;
    else if (tx_on) tx_drive_ff <= 1'b1;
    else if (tx_idle && !tx_full_ff) tx_drive_ff <= 1'b0;
  end
  wire logic tx_more = tx_full_ff;
  // Transmit complete: set wins over clear
  wire logic txc_clr = txc_irq_ack || (wr_stat && io_req.wdata[TXC_BIT]);
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) txc_ff <= 1'b0;
    else if (tx_done && !tx_more) txc_ff <= 1'b1;
    else if (txc_clr) txc_ff <= 1'b0;
  end

  // ==========================================================
  // Receiver
  logic [11:0] rx_sh_ff;
  logic [3:0] rx_left_ff;
  logic rx_hold_ff;          // Character waiting in shifter
  rx_char_t rx_hold_data_ff;
  wire logic rx_busy = rx_left_ff != 4'h0;
  wire logic rx_start = rx_on && !rx_busy && !rxd_in && bit_tick;
  wire logic rx_last = bit_tick && rx_left_ff == 4'h1;
  wire logic [11:0] rx_word = {rxd_in, rx_sh_ff[11:1]};
  // Align the assembled frame so bit 0 is the first data bit
  wire logic [11:0] rx_al = rx_word >> (4'hC - tx_len + 4'h1
    + {3'h0, frame_ff[STOP2_BIT]});
  wire logic [8:0] rx_dat = rx_al[8:0] & cmask;
  wire logic [3:0] dbits = tx_len - 4'h2 - {3'h0, frame_ff[PAR1_BIT]}
                           - {3'h0, frame_ff[STOP2_BIT]};
  wire logic rx_pbit = rx_al[dbits];
  wire logic rx_stop = rx_word[11];
  wire logic rx_addr = nine_bit ? rx_dat[8] : rx_stop;
  wire logic fifo_full = fifo_cnt_ff == 2'h2;
  // Frame assembly with one sample per bit period
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      rx_sh_ff <= 12'hFFF;
      rx_left_ff <= 4'h0;
    end else if (!rx_on) begin
      rx_left_ff <= 4'h0;
    end else if (rx_start) begin
      rx_left_ff <= tx_len - 4'h1 - {3'h0, frame_ff[STOP2_BIT]};
    end else if (bit_tick && rx_busy) begin
      rx_sh_ff <= rx_word;
      rx_left_ff <= rx_left_ff - 4'h1;
    end
  end
  // Completed character, filtered when multiprocessor mode is on
  wire logic rx_got = rx_last && (!stat_ff[MPF_BIT] || rx_addr);
  rx_char_t rx_new;
  assign rx_new = '{data: rx_dat, ferr: !rx_stop,
    perr: frame_ff[PAR1_BIT] && (^rx_dat ^ rx_pbit ^ frame_ff[PAR0_BIT])};
  wire logic push = rx_hold_ff && !fifo_full;
  wire logic pop = rd_data && fifo_cnt_ff != 2'h0;
  // Shifter holding stage and FIFO with flush on disable
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      rx_hold_ff <= 1'b0;
      rx_hold_data_ff <= '0;
      fifo_cnt_ff <= 2'h0;
      rd_ptr_ff <= 1'b0;
      ovr_ff <= 1'b0;
      for (int i = 0; i < FIFO_DEPTH; i++) fifo_ff[i] <= '0;
    end else if (!rx_on) begin
      rx_hold_ff <= 1'b0;
      fifo_cnt_ff <= 2'h0;
      ovr_ff <= 1'b0;
    end else begin
      if (rx_got) begin
        rx_hold_ff <= 1'b1;
        rx_hold_data_ff <= rx_new;
      end else if (push || (pop && fifo_full)) begin
        rx_hold_ff <= 1'b0;
      end
      if (push || (pop && fifo_full && rx_hold_ff)) begin
        fifo_ff[rd_ptr_ff ^ fifo_cnt_ff[0]] <= rx_hold_data_ff;
      end
      fifo_cnt_ff <= fifo_cnt_ff
        + {1'b0, push || (pop && fifo_full && rx_hold_ff)}
        - {1'b0, pop};
      if (pop) rd_ptr_ff <= !rd_ptr_ff;
      if (fifo_full && rx_hold_ff && rx_start) ovr_ff <= 1'b1;
      else if (pop) ovr_ff <= 1'b0;
    end
  end
  rx_char_t head;
  assign head = fifo_ff[rd_ptr_ff];

  // ==========================================================
  // Control register writes and shared location
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      stat_ff <= STAT_RESET;
      enab_ff <= ENAB_RESET;
      frame_ff <= FRAME_RESET;
      baud_hi_ff <= BAUD_HIGH_RESET;
      baud_lo_ff <= BAUD_LOW_RESET;
      shared_rd_ff <= 1'b0;
    end else begin
      shared_rd_ff <= rd_shared;
      if (wr_stat) stat_ff <= io_req.wdata & 8'h03;
      if (wr_enab) enab_ff <= io_req.wdata & 8'hFD;
      if (wr_baud_lo) baud_lo_ff <= io_req.wdata;
      if (wr_shared && io_req.wdata[SEL_BIT]) begin
        frame_ff <= io_req.wdata;
      end else if (wr_shared) begin
        baud_hi_ff <= io_req.wdata[3:0];
      end
    end
  end

  // ==========================================================
  // Read data and outputs
  wire logic has_rx = fifo_cnt_ff != 2'h0;
  wire logic [7:0] stat_rd = {has_rx, txc_ff, !tx_full_ff,
    has_rx && head.ferr, ovr_ff, has_rx && head.perr,
    stat_ff[1:0]};
  wire logic [7:0] enab_rd = {enab_ff[7:2], head.data[8],
    enab_ff[TX9_BIT]};
  // Second of two back-to-back reads sees frame control
  wire logic [7:0] shared_rd = shared_rd_ff ? frame_ff
                                : {4'h0, baud_hi_ff};
  wire logic [7:0] rd_mux =
    io_req.addr == ADDR_DATA ? head.data[7:0] :
    io_req.addr == ADDR_STAT ? stat_rd :
    io_req.addr == ADDR_ENAB ? enab_rd :
    io_req.addr == ADDR_SHARED ? shared_rd :
    io_req.addr == ADDR_BAUD_LOW ? baud_lo_ff : 8'h00;
  logic [7:0] rdata_ff;
  logic [2:0] irq_ff;
  // Registered read data and interrupt requests
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      rdata_ff <= 8'h00;
      irq_ff <= 3'h0;
    end else begin
      if (io_req.rd) rdata_ff <= rd_mux;
      irq_ff <= {enab_ff[RXIE_BIT] && has_rx,
                 enab_ff[TXIE_BIT] && txc_ff,
                 enab_ff[BEIE_BIT] && !tx_full_ff} &
                {3{global_irq_on}};
    end
  end
  assign io_rdata = rdata_ff;
  assign rxc_irq = irq_ff[2];
  assign txc_irq = irq_ff[1];
  assign tx_buffer_empty_flag_irq = irq_ff[0];
  assign txd_out = tx_line_ff;
  assign txd_oe = tx_drive_ff;
  assign rxd_owned = rx_on;

  // ==========================================================
  // Checks
  sequence two_reads_s;
    rd_shared ##1 rd_shared;
  endsequence
  shared_pair_a: assert property (two_reads_s
    |=> io_rdata == $past(frame_ff))
    else $error("paired shared read not frame control");
  shared_single_a: assert property (!shared_rd_ff && rd_shared
    |=> io_rdata == {4'h0, $past(baud_hi_ff)})
    else $error("single shared read not divisor high");
  drop_write_a: assert property (wr_data && tx_full_ff
    |=> $stable(tx_buf_ff))
    else $error("write into full buffer changed data");
  flush_a: assert property (!rx_on
    |=> fifo_cnt_ff == 2'h0 && !ovr_ff)
    else $error("receiver disable did not flush");
  txc_set_a: assert property (tx_done && !tx_more
    |=> txc_ff)
    else $error("tx complete did not set");
  irq_gate_a: assert property (!global_irq_on
    |=> !rxc_irq && !txc_irq && !tx_buffer_empty_flag_irq)
    else $error("interrupt without global enable");
  tx_hold_a: assert property (!tx_on && !tx_idle && tx_drive_ff
    |=> txd_oe)
    else $error("pin released mid frame");
  fifo_bound_a: assert property (fifo_cnt_ff <= 2'h2
    && stat_rd[RXC_BIT] == (fifo_cnt_ff != 2'h0))
    else $error("fifo count or rx flag wrong");
endmodule

// file: design/uart_regs_pkg.sv
// Package for the serial register interface: addresses, fields, resets.
package uart_regs_pkg;
  // Register addresses on the CPU I/O port (arbitrary local indices)
  localparam logic [2:0] ADDR_DATA = 3'h0;
  localparam logic [2:0] ADDR_STAT = 3'h1;
  localparam logic [2:0] ADDR_ENAB = 3'h2;
  localparam logic [2:0] ADDR_SHARED = 3'h3;
  localparam logic [2:0] ADDR_BAUD_LOW = 3'h4;
  // Reset values
  localparam logic [7:0] STAT_RESET = 8'h20;
  localparam logic [7:0] ENAB_RESET = 8'h00;
  localparam logic [7:0] FRAME_RESET = 8'h86;
  localparam logic [3:0] BAUD_HIGH_RESET = 4'h0;
  localparam logic [7:0] BAUD_LOW_RESET = 8'h00;
  // Status/control field positions
  localparam int RXC_BIT = 7;
  localparam int TXC_BIT = 6;
  localparam int TX_BUFFER_EMPTY_FLAG_BIT = 5;
  localparam int FERR_BIT = 4;
  localparam int OVR_BIT = 3;
  localparam int PERR_BIT = 2;
  localparam int DSPD_BIT = 1;
  localparam int MPF_BIT = 0;
  // Enable/control field positions
  localparam int RXIE_BIT = 7;
  localparam int TXIE_BIT = 6;
  localparam int BEIE_BIT = 5;
  localparam int RXON_BIT = 4;
  localparam int TXON_BIT = 3;
  localparam int SIZE2_BIT = 2;
  localparam int RX9_BIT = 1;
  localparam int TX9_BIT = 0;
  // Frame control field positions
  localparam int SEL_BIT = 7;
  localparam int SYNC_BIT = 6;
  localparam int PAR1_BIT = 5;
  localparam int PAR0_BIT = 4;
  localparam int STOP2_BIT = 3;
  // Oversampling divisors
  localparam logic [4:0] OVS_NORMAL = 5'h10;
  localparam logic [4:0] OVS_DOUBLE = 5'h08;
  localparam int FIFO_DEPTH = 2;
  // Received character with its error tags
  typedef struct packed {
    logic [8:0] data;
    logic ferr;
    logic perr;
  } rx_char_t;
  // CPU I/O request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } io_req_t;
endpackage

// file: tb/uart_register_interface_tb.sv
// Self-checking bench for the serial register interface.
`timescale 1ns/1ns
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
  err_total++; $display("FAIL t=%0t got %h exp %h", $time, g, e); end end
module uart_register_interface_tb;
  import uart_regs_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  uart_regs_pkg::io_req_t io_req = '0; // CPU request
  logic [7:0] io_rdata;
  logic global_irq_on = 1'b0;
  logic txc_irq_ack = 1'b0;
  logic rxd_in, txd_out, txd_oe, rxd_owned;
  logic rxc_irq, txc_irq, tx_buffer_empty_flag_irq;
  wire line_to_peer = txd_oe ? txd_out : 1'b1; // Port pull-up when released
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [7:0] v, v2;
  uart_register_interface uart_register_interface_i (
    .clk(clk), .rst_n(rst_n), .io_req(io_req), .io_rdata(io_rdata),
    .global_irq_on(global_irq_on), .txc_irq_ack(txc_irq_ack),
    .rxd_in(rxd_in), .txd_out(txd_out), .txd_oe(txd_oe),
    .rxd_owned(rxd_owned), .rxc_irq(rxc_irq), .txc_irq(txc_irq),
    .tx_buffer_empty_flag_irq(tx_buffer_empty_flag_irq));
  uart_remote_peer uart_remote_peer_i (
    .clk(clk), .line_in(line_to_peer), .line_out(rxd_in));
  // ==========================================
  // Clock and hang guard
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      print_verdict();
    end
  end
  // ==========================================
  // Bus tasks: one request (two in rd_pair), then one idle cycle
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    io_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge clk); #1;
    io_req = '0;
    @(posedge clk); #1;
  endtask
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    io_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge clk); #1;
    io_req = '0;
    d = io_rdata;
    @(posedge clk); #1;
  endtask
  // Two reads of the shared location in consecutive cycles
  task automatic rd_pair(output logic [7:0] a, output logic [7:0] b);
    io_req = '{rd: 1'b1, wr: 1'b0, addr: ADDR_SHARED, wdata: 8'h00};
    @(posedge clk); #1;
    a = io_rdata;
    @(posedge clk); #1;
    io_req = '0;
    b = io_rdata;
    @(posedge clk); #1;
  endtask
  task automatic wait_got(input int n);
    for (int k = 0; k < 2000 && uart_remote_peer_i.got_q.size() < n; k++)
      @(posedge clk);
    #1;
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset_values();
    `CHK(txd_out, 1'b1);
    rd_reg(ADDR_STAT, v); `CHK(v, STAT_RESET);
    rd_reg(ADDR_ENAB, v); `CHK(v, ENAB_RESET);
    rd_reg(ADDR_SHARED, v); `CHK(v, 8'h00);
  endtask
  task automatic t_shared();
    wr_reg(ADDR_SHARED, 8'h03);
    rd_pair(v, v2);
    `CHK(v, 8'h03);
    `CHK(v2, FRAME_RESET);
    rd_reg(ADDR_SHARED, v); `CHK(v, 8'h03);
    wr_reg(ADDR_SHARED, 8'h00);
    // Low byte write restarts the prescaler at the restored divisor
    wr_reg(ADDR_BAUD_LOW, 8'h00);
  endtask
  task automatic t_transmit();
    wr_reg(ADDR_ENAB, 8'h08);
    `CHK(txd_oe, 1'b1);
    wr_reg(ADDR_DATA, 8'hA5);
    wr_reg(ADDR_DATA, 8'h3C);
    wr_reg(ADDR_DATA, 8'hFF);
    rd_reg(ADDR_STAT, v); `CHK(v[TX_BUFFER_EMPTY_FLAG_BIT], 1'b0);
    wait_got(2);
    cycles(200);
    `CHK(uart_remote_peer_i.got_q.size(), 2);
    `CHK(uart_remote_peer_i.got_q[0], 8'hA5);
    `CHK(uart_remote_peer_i.got_q[1], 8'h3C);
    rd_reg(ADDR_STAT, v); `CHK(v, 8'h60);
    wr_reg(ADDR_ENAB, 8'h68);
    `CHK(txc_irq, 1'b0);
    `CHK(tx_buffer_empty_flag_irq, 1'b0);
    global_irq_on = 1'b1;
    cycles(2);
    `CHK(txc_irq, 1'b1);
    `CHK(tx_buffer_empty_flag_irq, 1'b1);
    txc_irq_ack = 1'b1;
    cycles(1);
    txc_irq_ack = 1'b0;
    cycles(2);
    `CHK(txc_irq, 1'b0);
    global_irq_on = 1'b0;
    rd_reg(ADDR_STAT, v); `CHK(v, 8'h20);
  endtask
  task automatic t_tx_disable();
    uart_remote_peer_i.got_q.delete();
    wr_reg(ADDR_DATA, 8'h81);
    wr_reg(ADDR_ENAB, 8'h00);
    `CHK(txd_oe, 1'b1);
    wait_got(1);
    `CHK(uart_remote_peer_i.got_q[0], 8'h81);
    cycles(20);
    `CHK(txd_oe, 1'b0);
    wr_reg(ADDR_STAT, 8'h40);
    rd_reg(ADDR_STAT, v); `CHK(v, 8'h20);
  endtask
  task automatic t_receive();
    wr_reg(ADDR_ENAB, 8'h90);
    `CHK(rxd_owned, 1'b1);
    uart_remote_peer_i.send(8'h5A, 8, 0, 1'b1);
    uart_remote_peer_i.send(8'h33, 8, 0, 1'b0);
    cycles(20);
    `CHK(rxc_irq, 1'b0);
    global_irq_on = 1'b1;
    cycles(2);
    `CHK(rxc_irq, 1'b1);
    global_irq_on = 1'b0;
    rd_reg(ADDR_STAT, v); `CHK(v, 8'hA0);
    rd_reg(ADDR_ENAB, v); `CHK(v, 8'h90);
    rd_reg(ADDR_DATA, v); `CHK(v, 8'h5A);
    rd_reg(ADDR_STAT, v); `CHK(v, 8'hB0);
    rd_reg(ADDR_DATA, v); `CHK(v, 8'h33);
    rd_reg(ADDR_STAT, v); `CHK(v, 8'h20);
  endtask
  task automatic t_short_parity();
    wr_reg(ADDR_SHARED, 8'hA4);
    rd_pair(v, v2); `CHK(v2, 8'hA4);
    uart_remote_peer_i.send(8'hFF, 7, 2, 1'b1);
    cycles(20);
    rd_reg(ADDR_STAT, v); `CHK(v, 8'hA4);
    rd_reg(ADDR_DATA, v); `CHK(v, 8'h7F);
    wr_reg(ADDR_SHARED, FRAME_RESET);
  endtask
  task automatic t_double_speed();
    wr_reg(ADDR_STAT, 8'h02);
    uart_remote_peer_i.bit_clks = 8;
    uart_remote_peer_i.send(8'h96, 8, 0, 1'b1);
    cycles(20);
    rd_reg(ADDR_DATA, v); `CHK(v, 8'h96);
    rd_reg(ADDR_STAT, v); `CHK(v, 8'h22);
    wr_reg(ADDR_STAT, 8'h00);
    uart_remote_peer_i.bit_clks = 16;
  endtask
  // Filter on: a frame with a zero first stop bit carries no address
  task automatic t_filter();
    wr_reg(ADDR_STAT, 8'h01);
    uart_remote_peer_i.send(8'h11, 8, 0, 1'b0);
    uart_remote_peer_i.send(8'h22, 8, 0, 1'b1);
    cycles(20);
    rd_reg(ADDR_DATA, v); `CHK(v, 8'h22);
    rd_reg(ADDR_STAT, v); `CHK(v, 8'h21);
    wr_reg(ADDR_STAT, 8'h00);
  endtask
  task automatic t_overrun_flush();
    for (int i = 1; i <= 4; i++)
      uart_remote_peer_i.send(8'(i), 8, 0, 1'b1);
    cycles(20);
    rd_reg(ADDR_STAT, v); `CHK(v, 8'hA8);
    wr_reg(ADDR_ENAB, 8'h00);
    `CHK(rxd_owned, 1'b0);
    rd_reg(ADDR_STAT, v); `CHK(v, 8'h20);
  endtask
  // ==========================================
  // Verdict and main sequence
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    cycles(6);
    rst_n = 1'b1;
    cycles(4);
    t_reset_values();
    t_shared();
    t_transmit();
    t_tx_disable();
    t_receive();
    t_short_parity();
    t_double_speed();
    t_filter();
    t_overrun_flush();
    print_verdict();
  end
endmodule

// file: tb/uart_remote_peer.sv
// Remote serial transceiver model facing the block's serial pins.
`timescale 1ns/1ns
module uart_remote_peer (
  input wire logic clk,
  input wire logic line_in,
  output logic line_out
);
  int bit_clks = 16; // Clocks per serial bit
  int rx_bits = 8; // Data bits expected from the block
  logic [7:0] got_q[$]; // Characters collected from the block
  logic [7:0] acc; // Character being collected
  initial line_out = 1'b1;
  // ==========================================
  // Sending side
  // Hold the line for one bit, changing only just after an edge
  task automatic hold_bit();
    repeat (bit_clks) @(posedge clk);
    #1;
  endtask
  // Start, data low bit first, optional parity (1 even, 2 wrong), stop
  task automatic send(input logic [7:0] d, input int n, input int par,
                      input logic stp);
    line_out = 1'b0;
    hold_bit();
    for (int i = 0; i < n; i++) begin
      line_out = d[i];
      hold_bit();
    end
    if (par != 0) begin
      line_out = (^(d & ((8'h01 << n) - 8'h01))) ^ (par == 2);
      hold_bit();
    end
    // Stop bit, zero when a framing fault is wanted
    line_out = stp;
    hold_bit();
    // Idle mark before the next frame
    line_out = 1'b1;
    hold_bit();
  endtask
  // ==========================================
  // Receiving side: sample each bit at its middle
  always begin
    @(negedge line_in);
    acc = 8'h00;
    repeat (bit_clks / 2) @(posedge clk);
    for (int i = 0; i < rx_bits; i++) begin
      repeat (bit_clks) @(posedge clk);
      acc[i] = line_in;
    end
    repeat (bit_clks) @(posedge clk);
    got_q.push_back(acc);
  end
endmodule
